/* src/hls_defs.svh */
// Constants for the link split and start-up block.
// Assumes a 40 MHz core clock and a synchronous active-low reset.
`ifndef HLS_DEFS_SVH
`define HLS_DEFS_SVH
`define HLS_ADDR_CTRL 4'h0
`define HLS_ADDR_STAT 4'h1
`define HLS_ADDR_LO_CFG 4'h2
`define HLS_ADDR_HI_CFG 4'h3
`define HLS_CFG_WIDTH_BIT 0
`define HLS_CFG_RATE_LSB 1
`define HLS_CFG_RATE_MSB 3
`define HLS_CFG_REV_BIT 4
`define HLS_CFG_RESET 5'h10
`define HLS_RATE_RESET 3'h0
`define HLS_RATE_MAX 3'h5
`define HLS_TRAIN_NS 1000
`define HLS_CLK_NS 25
`define HLS_TRAIN_CYC ((`HLS_TRAIN_NS + `HLS_CLK_NS - 1) / `HLS_CLK_NS)
`define HLS_ADDR_SEL_BIT 40
`endif

/* src/hls_pkg.sv */
// Types for the link split and start-up block.
// Included ahead of the design module.
package hls_pkg;
   typedef enum logic [1:0]
   {
      HLS_IDLE = 2'b00,
      HLS_TRAIN = 2'b01,
      HLS_DONE = 2'b11,
      HLS_STOPPED = 2'b10
   } hls_state_t;
endpackage

/* src/hls_link_split.sv */
// Link split, sideband direction and start-up training for one port.
// Assumes pins are asynchronous; link signals sampled by core_clk.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "hls_defs.svh"
module hls_link_split
   import hls_pkg::*;
#(
   parameter int TRAIN_CYC = `HLS_TRAIN_CYC
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Strap pins
   input wire logic link_split_select,
   input wire logic low_half_master_select,
   input wire logic high_half_master_select,
   // Sideband pins, index 0 low half, 1 high half
   input wire logic [1:0] pwrok_in,
   output logic [1:0] pwrok_out,
   output logic [1:0] pwrok_oe_n,
   input wire logic [1:0] rst_n_in,
   output logic [1:0] rst_n_out,
   output logic [1:0] rst_n_oe_n,
   input wire logic [1:0] stop_n_in,
   output logic [1:0] stop_n_out,
   output logic [1:0] stop_n_oe_n,
   input wire logic [1:0] req_n_in,
   // Forwarded link clocks
   input wire logic [1:0] rx_link_clk,
   // Lane ownership, 1 means high-half controller
   output logic [1:0] clk_lane_hi,
   output logic [1:0] ctl_lane_hi,
   output logic ctl_lane1_used,
   output logic [15:0] cad_lane_hi,
   // Request routing from the controllers
   input wire logic [63:0] req_addr,
   input wire logic req_valid,
   input wire logic [1:0] req_miss,
   output logic [1:0] req_to_half,
   output logic [1:0] miss_forward,
   output logic [1:0] miss_error,
   output logic [1:0] bridge_bit,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);

   initial
   begin
      if (TRAIN_CYC < 8 || TRAIN_CYC / 8 > 65535)
         $error("TRAIN_CYC out of range");
   end

   // Three-stage synchronisers for all pin inputs, stage 0 newest
   logic [2:0] split_sync_reg;
   logic [2:0] lo_ms_sync_reg;
   logic [2:0] hi_ms_sync_reg;
   logic [2:0][1:0] pwrok_sync_reg;
   logic [2:0][1:0] rst_sync_reg;
   logic [2:0][1:0] stop_sync_reg;
   logic [2:0][1:0] req_sync_reg;
   logic [2:0][1:0] lclk_sync_reg;
   // Filtered levels: change only when stages two and three agree
   logic [1:0] pwrok_f_reg;
   logic [1:0] rst_f_reg;
   logic [1:0] stop_f_reg;
   logic [1:0] req_f_reg;
   logic [1:0] lclk_f_reg;
   logic [1:0] lclk_prev_reg;

   function automatic logic [1:0] hls_filt(input logic [1:0] s2, input logic [1:0] s3,
                                           input logic [1:0] cur);
      hls_filt = (s2 & s3) | (cur & (s2 | s3));
   endfunction

   // Reset levels match idle pins, so no false edge after reset
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         split_sync_reg <= 3'h0;
         lo_ms_sync_reg <= 3'h0;
         hi_ms_sync_reg <= 3'h0;
         pwrok_sync_reg <= 6'h00;
         rst_sync_reg <= 6'h00;
         stop_sync_reg <= 6'h3F;
         req_sync_reg <= 6'h3F;
         lclk_sync_reg <= 6'h00;
         pwrok_f_reg <= 2'h0;
         rst_f_reg <= 2'h0;
         stop_f_reg <= 2'h3;
         req_f_reg <= 2'h3;
         lclk_f_reg <= 2'h0;
         lclk_prev_reg <= 2'h0;
      end
      else
      begin
         split_sync_reg <= {split_sync_reg[1:0], link_split_select};
         lo_ms_sync_reg <= {lo_ms_sync_reg[1:0], low_half_master_select};
         hi_ms_sync_reg <= {hi_ms_sync_reg[1:0], high_half_master_select};
         pwrok_sync_reg <= {pwrok_sync_reg[1:0], pwrok_in};
         rst_sync_reg <= {rst_sync_reg[1:0], rst_n_in};
         stop_sync_reg <= {stop_sync_reg[1:0], stop_n_in};
         req_sync_reg <= {req_sync_reg[1:0], req_n_in};
         lclk_sync_reg <= {lclk_sync_reg[1:0], rx_link_clk};
         pwrok_f_reg <= hls_filt(pwrok_sync_reg[1], pwrok_sync_reg[2], pwrok_f_reg);
         rst_f_reg <= hls_filt(rst_sync_reg[1], rst_sync_reg[2], rst_f_reg);
         stop_f_reg <= hls_filt(stop_sync_reg[1], stop_sync_reg[2], stop_f_reg);
         req_f_reg <= hls_filt(req_sync_reg[1], req_sync_reg[2], req_f_reg);
         lclk_f_reg <= hls_filt(lclk_sync_reg[1], lclk_sync_reg[2], lclk_f_reg);
         lclk_prev_reg <= lclk_f_reg;
      end
   end

   // Straps caught once after reset release; held until the next reset
   logic split_reg;
   logic [1:0] master_reg;
   logic [1:0] slave_flag_reg;
   logic strap_done_reg;
   logic [1:0] strap_wait_reg;

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         split_reg <= 1'b0;
         master_reg <= 2'h0;
         strap_done_reg <= 1'b0;
         strap_wait_reg <= 2'h0;
      end
      else if (!strap_done_reg)
      begin
         strap_wait_reg <= strap_wait_reg + 2'h1;
         if (strap_wait_reg == 2'h3)
         begin
            strap_done_reg <= 1'b1;
            split_reg <= split_sync_reg[2];
            master_reg <= {hi_ms_sync_reg[2], lo_ms_sync_reg[2]};
         end
      end
   end

   // Active halves: high half only exists when split
   logic [1:0] half_active;
   assign half_active = {split_reg, 1'b1};

   // Software config: width bit, rate code, protocol revision
   logic [4:0] cfg_reg [2];
   logic [1:0] reinit_req_reg;
   logic [1:0] done_reg;
   logic [1:0] wide_reg;
   logic [2:0] rate_reg [2];
   hls_state_t state_reg [2];
   logic [15:0] train_cnt_reg [2];

   // Legal width for revision: 1.0 forces 8 bits
   function automatic logic hls_wide_ok(input logic [4:0] cfg, input logic split);
      hls_wide_ok = cfg[`HLS_CFG_WIDTH_BIT] & cfg[`HLS_CFG_REV_BIT] & !split;
   endfunction

   // software rewrite of width and rate
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         cfg_reg[0] <= `HLS_CFG_RESET;
         cfg_reg[1] <= `HLS_CFG_RESET;
         slave_flag_reg <= 2'h0;
         reinit_req_reg <= 2'h0;
      end
      else
      begin
         if (strap_done_reg == 1'b0 && strap_wait_reg == 2'h3)
            slave_flag_reg <= ~{hi_ms_sync_reg[2], lo_ms_sync_reg[2]};
         for (int h = 0; h < 2; h++)
         begin
            if (reg_wr && reg_addr == (h == 0 ? `HLS_ADDR_LO_CFG : `HLS_ADDR_HI_CFG))
               cfg_reg[h] <= reg_wdata[4:0];
            // reinit only by warm reset or stop
            if (reg_wr && reg_addr == `HLS_ADDR_CTRL && reg_wdata[h])
               reinit_req_reg[h] <= 1'b1;
            else if (state_reg[h] == HLS_TRAIN)
               reinit_req_reg[h] <= 1'b0;
         end
         if (reg_wr && reg_addr == `HLS_ADDR_CTRL)
            slave_flag_reg <= reg_wdata[5:4];
      end
   end

   // Per-half training state machine
   // automatic init
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         for (int h = 0; h < 2; h++)
         begin
            state_reg[h] <= HLS_IDLE;
            train_cnt_reg[h] <= 16'h0;
            rate_reg[h] <= `HLS_RATE_RESET;
         end
         done_reg <= 2'h0;
         wide_reg <= 2'h0;
      end
      else
      begin
         for (int h = 0; h < 2; h++)
         begin
            case (state_reg[h])
               HLS_IDLE:
               begin
                  if (strap_done_reg && half_active[h] && rst_n_out[h] && stop_n_out[h])
                  begin
                     state_reg[h] <= HLS_TRAIN;
                     train_cnt_reg[h] <= 16'h0;
                  end
               end
               HLS_TRAIN:
               begin
                  if (lclk_f_reg[h] && !lclk_prev_reg[h])
                     train_cnt_reg[h] <= train_cnt_reg[h] + 16'h1;
                  if (train_cnt_reg[h] >= 16'(TRAIN_CYC / 8))
                  begin
                     state_reg[h] <= HLS_DONE;
                     done_reg[h] <= 1'b1;
                  end
               end
               HLS_DONE:
               begin
                  if (!stop_n_out[h] || !rst_n_out[h])
                  begin
                     state_reg[h] <= HLS_STOPPED;
                     done_reg[h] <= 1'b0;
                     wide_reg[h] <= hls_wide_ok(cfg_reg[h], split_reg) & reinit_req_reg[h];
                     if (reinit_req_reg[h] && cfg_reg[h][3:1] <= `HLS_RATE_MAX)
                        rate_reg[h] <= cfg_reg[h][3:1];
                  end
               end
               HLS_STOPPED:
               begin
                  if (stop_n_out[h] && rst_n_out[h])
                     state_reg[h] <= HLS_IDLE;
               end
               default: state_reg[h] <= HLS_IDLE;
            endcase
         end
      end
   end

   // Sideband drive and view, per half
   // sideband direction
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         pwrok_out <= 2'h0;
         rst_n_out <= 2'h0;
         stop_n_out <= 2'h3;
         {pwrok_oe_n, rst_n_oe_n, stop_n_oe_n} <= 6'h3F;
      end
      else
      begin
         for (int h = 0; h < 2; h++)
         begin
            if (master_reg[h] && half_active[h] && strap_done_reg)
            begin
               {pwrok_oe_n[h], rst_n_oe_n[h], stop_n_oe_n[h]} <= 3'h0;
               pwrok_out[h] <= 1'b1;
               rst_n_out[h] <= 1'b1;
               stop_n_out[h] <= !(reinit_req_reg[h] && state_reg[h] == HLS_DONE);
            end
            else
            begin
               {pwrok_oe_n[h], rst_n_oe_n[h], stop_n_oe_n[h]} <= 3'h7;
               pwrok_out[h] <= pwrok_f_reg[h] & half_active[h];
               rst_n_out[h] <= rst_f_reg[h] & pwrok_f_reg[h] & half_active[h];
               stop_n_out[h] <= (stop_f_reg[h] & req_f_reg[h]) | !half_active[h];
            end
         end
      end
   end

   // Lane ownership and request routing
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         {clk_lane_hi, ctl_lane_hi, ctl_lane1_used, cad_lane_hi} <= 21'h0;
         {req_to_half, miss_forward, miss_error, bridge_bit} <= 8'h00;
      end
      else
      begin
         clk_lane_hi <= {split_reg, 1'b0};
         ctl_lane_hi <= {split_reg, 1'b0};
         ctl_lane1_used <= split_reg;
         cad_lane_hi <= {{8{split_reg}}, 8'h00};
         req_to_half[1] <= req_valid & split_reg & req_addr[`HLS_ADDR_SEL_BIT];
         req_to_half[0] <= req_valid & !(split_reg & req_addr[`HLS_ADDR_SEL_BIT]);
         bridge_bit <= ~slave_flag_reg & half_active;
         miss_forward <= req_miss & ~slave_flag_reg & half_active;
         miss_error <= req_miss & slave_flag_reg & half_active;
      end
   end

   // Register read, one cycle latency
   // status readback
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
         reg_rdata <= 32'h0;
      else if (reg_rd)
      begin
         case (reg_addr)
            `HLS_ADDR_CTRL: reg_rdata <= {26'h0, slave_flag_reg, 2'h0, reinit_req_reg};
            `HLS_ADDR_STAT: reg_rdata <= {21'h0, rate_reg[1], rate_reg[0], split_reg,
                                          wide_reg, done_reg};
            `HLS_ADDR_LO_CFG: reg_rdata <= {27'h0, cfg_reg[0]};
            `HLS_ADDR_HI_CFG: reg_rdata <= {27'h0, cfg_reg[1]};
            default: reg_rdata <= 32'h0;
         endcase
      end
      else
         reg_rdata <= 32'h0;
   end

   bridge_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ##1 $past(half_active[0]) |-> bridge_bit[0] == !$past(slave_flag_reg[0]))
      else $error("bridge bit wrong");

   miss_excl_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !(miss_forward[0] && miss_error[0]))
      else $error("miss both forward and error");

   unsplit_route_a: assert property (@(posedge core_clk) disable iff (!nrst)
      !split_reg && req_valid ##1 !split_reg |-> req_to_half == 2'b01)
      else $error("unsplit request left low half");

   cad_lanes_a: assert property (@(posedge core_clk) disable iff (!nrst)
      ##1 split_reg && $stable(split_reg) |-> cad_lane_hi == 16'hFF00)
      else $error("split data lanes wrong");

   hi_ignore_a: assert property (@(posedge core_clk) disable iff (!nrst)
      strap_done_reg && !split_reg |-> state_reg[1] == HLS_IDLE && !done_reg[1])
      else $error("high half active while unsplit");
   master_drive_a: assert property (@(posedge core_clk) disable iff (!nrst)
      strap_done_reg && master_reg[0] ##1 1'b1 |-> pwrok_oe_n[0] == 1'b0)
      else $error("master half not driving");
   strap_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
      strap_done_reg |=> $stable(split_reg) && $stable(master_reg))
      else $error("strap changed in operation");
   cold_rate_a: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(strap_done_reg) |-> rate_reg[0] == `HLS_RATE_RESET && !wide_reg[0])
      else $error("cold start not at lowest rate");

endmodule
`default_nettype wire

/* verif/hls_peer_model.sv */
// Peer link device facing the split and start-up block.
// Assumes device oe_n outputs are low while the device drives a pin.
`timescale 1ns/1ps
`default_nettype none
module hls_peer_model
(
   // Peer readiness, low holds the link down on halves the device does not drive
   input wire logic peer_up,
   // Device pin drivers
   input wire logic [1:0] pwrok_out,
   input wire logic [1:0] pwrok_oe_n,
   input wire logic [1:0] rst_n_out,
   input wire logic [1:0] rst_n_oe_n,
   input wire logic [1:0] stop_n_out,
   input wire logic [1:0] stop_n_oe_n,
   // Resolved pin levels
   output logic [1:0] pwrok_in,
   output logic [1:0] rst_n_in,
   output logic [1:0] stop_n_in,
   output logic [1:0] req_n_in,
   output logic [1:0] rx_link_clk
);
   logic [1:0] up;
   assign up = {2{peer_up}};
   assign pwrok_in = (pwrok_oe_n & up) | (~pwrok_oe_n & pwrok_out);
   assign rst_n_in = (rst_n_oe_n & up) | (~rst_n_oe_n & rst_n_out);
   assign stop_n_in = (stop_n_oe_n & up) | (~stop_n_oe_n & stop_n_out);
   assign req_n_in = 2'b11;
   initial
   begin
      rx_link_clk = 2'b00;
      forever
      begin
         #100;
         rx_link_clk = rx_link_clk ^ (pwrok_in & rst_n_in & stop_n_in);
      end
   end
endmodule
`default_nettype wire

/* verif/hls_link_split_test.sv */
// Self-checking bench for the link split and start-up block.
// Assumes the peer model resolves sideband pins and makes link clocks.
`timescale 1ns/1ps
`default_nettype none
`include "hls_defs.svh"
module hls_link_split_test;
   logic core_clk, nrst, link_split_select, low_half_master_select;
   logic high_half_master_select, peer_up, ctl_lane1_used, req_valid, reg_wr, reg_rd;
   logic [1:0] pwrok_in, pwrok_out, pwrok_oe_n, rst_n_in, rst_n_out, rst_n_oe_n;
   logic [1:0] stop_n_in, stop_n_out, stop_n_oe_n, req_n_in, rx_link_clk;
   logic [1:0] clk_lane_hi, ctl_lane_hi, req_miss, req_to_half;
   logic [1:0] miss_forward, miss_error, bridge_bit;
   logic [15:0] cad_lane_hi;
   logic [63:0] req_addr;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rdv;
   int error_cnt = 0;
   int n_tests = 0;
   int stop_lows = 0;

   hls_link_split #(.TRAIN_CYC(16)) i_hls_link_split (.core_clk, .nrst, .link_split_select,
      .low_half_master_select, .high_half_master_select, .pwrok_in, .pwrok_out, .pwrok_oe_n,
      .rst_n_in, .rst_n_out, .rst_n_oe_n, .stop_n_in, .stop_n_out, .stop_n_oe_n, .req_n_in,
      .rx_link_clk, .clk_lane_hi, .ctl_lane_hi, .ctl_lane1_used, .cad_lane_hi, .req_addr,
      .req_valid, .req_miss, .req_to_half, .miss_forward, .miss_error, .bridge_bit, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   hls_peer_model i_hls_peer_model (.peer_up, .pwrok_out, .pwrok_oe_n, .rst_n_out,
      .rst_n_oe_n, .stop_n_out, .stop_n_oe_n, .pwrok_in, .rst_n_in, .stop_n_in, .req_n_in,
      .rx_link_clk);

   initial
   begin
      core_clk = 1'b0;
      forever
      begin
         #12.5 core_clk = ~core_clk;
      end
   end

   // Low half stop driven low by the device
   always @(posedge core_clk)
      if (stop_n_oe_n[0] === 1'b0 && stop_n_out[0] === 1'b0)
         stop_lows <= stop_lows + 1;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("mismatches %0d, checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic reset_dut(input logic s, input logic lo, input logic hi);
      @(posedge core_clk);
      nrst <= 1'b0;
      link_split_select <= s;
      low_half_master_select <= lo;
      high_half_master_select <= hi;
      repeat (8) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (6) @(posedge core_clk);
   endtask

   // Bounded poll of the status word
   task automatic wait_stat(input logic [31:0] mask, input logic [31:0] val);
      int i;
      for (i = 0; i < 100; i++)
      begin
         rd(`HLS_ADDR_STAT, rdv);
         if ((rdv & mask) === val)
            return;
      end
      error_cnt++;
      $display("unexpected status wait: expected %h, seen %h", val, rdv & mask);
      test_done();
   endtask

   // Outputs packed as half, forward, error, bridge
   task automatic route(input logic a40, input logic [7:0] exp);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_addr <= {23'h0, a40, 40'h0};
      req_miss <= 2'b11;
      repeat (2) @(posedge core_clk);
      #1;
      check("routing", {24'h0, req_to_half, miss_forward, miss_error, bridge_bit}, {24'h0, exp});
   endtask

   task automatic sc_unsplit_slave();
      peer_up <= 1'b0;
      reset_dut(1'b0, 1'b0, 1'b1);
      rd(`HLS_ADDR_CTRL, rdv);
      check("role flags", {30'h0, rdv[5:4]}, 32'h1);
      check("power release", {31'h0, pwrok_oe_n[0]}, 32'h1);
      check("lanes", {11'h0, clk_lane_hi, ctl_lane_hi, ctl_lane1_used, cad_lane_hi}, 32'h0);
      repeat (40) @(posedge core_clk);
      rd(`HLS_ADDR_STAT, rdv);
      check("held by peer", {31'h0, rdv[0]}, 32'h0);
      peer_up <= 1'b1;
      wait_stat(32'h11, 32'h01);
      route(1'b1, 8'h44);
      @(posedge core_clk);
      link_split_select <= 1'b1;
      low_half_master_select <= 1'b1;
      repeat (10) @(posedge core_clk);
      #1;
      check("held lanes", {15'h0, ctl_lane1_used, cad_lane_hi}, 32'h0);
   endtask

   task automatic sc_split_master();
      int lows;
      peer_up <= 1'b1;
      reset_dut(1'b1, 1'b1, 1'b0);
      rd(`HLS_ADDR_CTRL, rdv);
      check("role flags", {30'h0, rdv[5:4]}, 32'h2);
      check("power drive", {30'h0, pwrok_oe_n}, 32'h2);
      check("reset drive", {30'h0, rst_n_oe_n}, 32'h2);
      check("stop drive", {30'h0, stop_n_oe_n}, 32'h2);
      check("master levels", {30'h0, pwrok_out[0], rst_n_out[0]}, 32'h3);
      check("clk lanes", {30'h0, clk_lane_hi}, 32'h2);
      check("ctl lanes", {29'h0, ctl_lane1_used, ctl_lane_hi}, 32'h6);
      check("data lanes", {16'h0, cad_lane_hi}, 32'hFF00);
      wait_stat(32'h3, 32'h3);
      check("trained status", rdv & 32'h7FC, 32'h10);
      route(1'b1, 8'h99);
      route(1'b0, 8'h59);
      wr(`HLS_ADDR_CTRL, 32'h10);
      route(1'b1, 8'hA6);
      rd(`HLS_ADDR_HI_CFG, rdv);
      check("high config", rdv, 32'h10);
      wr(4'h7, 32'hFFFF_FFFF);
      rd(4'h7, rdv);
      check("unmapped read", rdv, 32'h0);
      @(posedge core_clk);
      #1;
      check("idle read data", reg_rdata, 32'h0);
      wr(`HLS_ADDR_LO_CFG, 32'h14);
      rd(`HLS_ADDR_LO_CFG, rdv);
      check("low config", rdv, 32'h14);
      rd(`HLS_ADDR_STAT, rdv);
      check("rate before reinit", {29'h0, rdv[7:5]}, 32'h0);
      lows = stop_lows;
      wr(`HLS_ADDR_CTRL, 32'h11);
      wait_stat(32'hE3, 32'h43);
      check("stop pulse", {31'h0, stop_lows > lows}, 32'h1);
   endtask

   initial
   begin
      nrst = 1'b0;
      link_split_select = 1'b0;
      low_half_master_select = 1'b0;
      high_half_master_select = 1'b0;
      peer_up = 1'b0;
      req_valid = 1'b0;
      req_addr = 64'h0;
      req_miss = 2'b00;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sc_unsplit_slave();
      sc_split_master();
      test_done();
   end
endmodule
`default_nettype wire
